// >>> hw/reset_and_clock_guard.sv
// reset sequencing, reset pin drive, oscillator choice and clock guard.
// assumes pin inputs synchronous to clk; reset pin resolved outside.
`timescale 1ns/100ps
module reset_and_clock_guard #(
    parameter int unsigned SETTLE   = rcg_pkg::SETTLE_CYC,
    parameter int unsigned RSTL_OUT = rcg_pkg::RSTL_OUT_CYC,
    parameter int unsigned RSTL_IN  = rcg_pkg::RSTL_IN_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // open-drain reset pin
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    // reset sources
    input  wire logic        supply_low,
    input  wire logic        wdg_underflow,
    // option bits
    input  wire logic [2:0]  osc_select_opt,
    input  wire logic        guard_enable_opt,
    // oscillators
    input  wire logic        main_osc_in,
    output logic             sys_clk_out,
    output logic             resonator_run,
    output logic [2:0]       osc_kind,
    output logic             backup_osc_on,
    // core state and interrupts
    input  wire logic        wait_mode,
    input  wire logic        halt_mode,
    input  wire logic        active_halt_mode,
    input  wire logic        global_irq_mask,
    output logic             core_reset,
    output logic             guard_irq,
    output logic             wake_req
);

    typedef enum logic [1:0] {ST_LOW, ST_SETTLE, ST_FETCH, ST_RUN} seq_type;

    seq_type     seq_q;
    logic [15:0] cnt_q;
    logic        pin_s1_q, pin_s2_q;
    logic [7:0]  ext_low_q;
    logic [1:0]  holdoff_q;
    logic        ext_hit, wdg_hit, src_hit;
    logic        drop_flag_q, wdg_flag_q, safe_flag_q, irq_en_q;
    logic        guard_on, main_clean, main_good;
    logic        use_backup_q, backup_clk_q;
    logic [7:0]  div_q;
    logic        apb_done, wr_hit, rd_hit, status_sel;
    logic [7:0]  status_view;

    // two-stage synchroniser on the reset pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= rst_pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // external low width, ignoring our own drive and its tail
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_low_q <= 8'h00;
            holdoff_q <= 2'b00;
        end else begin
            if (rst_pin_oe) begin
                holdoff_q <= 2'(rcg_pkg::PIN_HOLDOFF_CYC);
            end else if (holdoff_q != 2'b00) begin
                holdoff_q <= holdoff_q - 2'b01;
            end
            // counted regardless of halt
            if (pin_s2_q || rst_pin_oe || holdoff_q != 2'b00) begin
                ext_low_q <= 8'h00;
            end else if (ext_low_q != 8'hFF) begin
                ext_low_q <= ext_low_q + 8'h01;
            end
        end
    end

    assign ext_hit = ext_low_q == 8'(RSTL_IN);
    assign wdg_hit = wdg_underflow && seq_q == ST_RUN;
    assign src_hit = ext_hit || wdg_hit || supply_low;

    // reset sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_q <= ST_LOW;
            cnt_q <= 16'h0000;
        end else if (src_hit && seq_q != ST_LOW) begin
            seq_q <= ST_LOW;
            cnt_q <= 16'h0000;
        end else begin
            unique case (seq_q)
                ST_LOW: begin
                    if (supply_low) begin
                        cnt_q <= 16'h0000;
                    end else if (cnt_q == 16'(RSTL_OUT - 1)) begin
                        seq_q <= ST_SETTLE;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_q == 16'(SETTLE - 1)) begin
                        seq_q <= ST_FETCH;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_FETCH: begin
                    if (cnt_q == 16'(rcg_pkg::FETCH_CYC - 1)) begin
                        seq_q <= ST_RUN;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_RUN: begin
                    cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // pin drive and core reset follow the sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_pin_oe  <= 1'b1;
            rst_pin_out <= 1'b0;
            core_reset  <= 1'b1;
        end else begin
            rst_pin_out <= 1'b0;
            rst_pin_oe  <= src_hit || (seq_q == ST_LOW && !(cnt_q == 16'(RSTL_OUT - 1) && !supply_low));
            core_reset  <= src_hit || seq_q != ST_RUN;
        end
    end

    // oscillator choice latched from option bits, resonators never stopped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_kind      <= 3'(rcg_pkg::OSC_INT_RC);
            resonator_run <= 1'b0;
        end else begin
            osc_kind      <= osc_select_opt;
            resonator_run <= osc_select_opt >= 3'(rcg_pkg::OSC_RES_RANGE0)
                          && osc_select_opt <= 3'(rcg_pkg::OSC_RES_RANGE3);
        end
    end

    // guard active only by option bit and outside halt
    assign guard_on = guard_enable_opt && !halt_mode;

    clock_spike_filter u_filter (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .enable    (guard_on),
        .osc_in    (main_osc_in),
        .osc_clean (main_clean),
        .osc_good  (main_good)
    );

    // backup oscillator from a divider, off while guard is off
    always_ff @(posedge clk) begin
        if (sys_rst || !guard_on) begin
            div_q        <= 8'h00;
            backup_clk_q <= 1'b0;
        end else if (div_q == 8'(rcg_pkg::BACKUP_HALF_CYC - 1)) begin
            div_q        <= 8'h00;
            backup_clk_q <= !backup_clk_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // source select changes only while both clocks and output are low, or returns to main at once when guard is off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            use_backup_q  <= 1'b0;
            backup_osc_on <= 1'b0;
        end else begin
            backup_osc_on <= guard_on;
            if (!guard_on) begin
                use_backup_q <= 1'b0;
            end else if (!sys_clk_out && !main_clean && !backup_clk_q) begin
                use_backup_q <= !main_good;
            end
        end
    end

    // system clock output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sys_clk_out <= 1'b0;
        end else begin
            sys_clk_out <= use_backup_q ? backup_clk_q : main_clean;
        end
    end

    // apb handshake, one wait state
    assign apb_done = psel && penable && pready;
    assign status_sel = paddr == rcg_pkg::STATUS_ADDR;
    assign wr_hit     = apb_done && pwrite && status_sel;
    assign rd_hit     = apb_done && !pwrite && status_sel;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !status_sel;
            prdata  <= (psel && !pwrite && status_sel) ? {24'h00_0000, status_view} : 32'h0000_0000;
        end
    end

    // status view, flag forced low without guard
    always_comb begin
        status_view                         = 8'h00;
        status_view[rcg_pkg::DROP_FLAG_BIT] = drop_flag_q;
        status_view[rcg_pkg::IRQ_EN_BIT]    = irq_en_q;
        status_view[rcg_pkg::SAFE_FLAG_BIT] = safe_flag_q && guard_enable_opt;
        status_view[rcg_pkg::WDG_FLAG_BIT]  = wdg_flag_q;
    end

    // reset cause flags: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drop_flag_q <= rcg_pkg::FLAG_RESET;
            wdg_flag_q  <= rcg_pkg::FLAG_RESET;
        end else if (supply_low) begin
            drop_flag_q <= 1'b1;
            wdg_flag_q <= 1'b0;
        end else if (wdg_hit) begin
            wdg_flag_q <= 1'b1;
        end else if (wr_hit && !halt_mode) begin
            if (!pwdata[rcg_pkg::DROP_FLAG_BIT]) drop_flag_q <= 1'b0;
            if (!pwdata[rcg_pkg::WDG_FLAG_BIT]) wdg_flag_q <= 1'b0;
        end
    end

    // interrupt enable: kept across halt, reset value on any device reset
    always_ff @(posedge clk) begin
        if (sys_rst || core_reset) begin
            irq_en_q <= rcg_pkg::IRQ_EN_RESET;
        end else if (wr_hit && !halt_mode) begin
            irq_en_q <= pwdata[rcg_pkg::IRQ_EN_BIT];
        end
    end

    // safe clock flag: set on backup take-over, read clears after recovery
    always_ff @(posedge clk) begin
        if (sys_rst || !guard_enable_opt) begin
            safe_flag_q <= rcg_pkg::FLAG_RESET;
        end else if (halt_mode) begin
            safe_flag_q <= safe_flag_q;
        end else if (!use_backup_q && !sys_clk_out && !main_clean && !backup_clk_q && !main_good) begin
            safe_flag_q <= 1'b1;
        end else if (rd_hit && main_good && !use_backup_q) begin
            safe_flag_q <= 1'b0;
        end
    end

    // interrupt request and wake
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            guard_irq <= 1'b0;
            wake_req  <= 1'b0;
        end else begin
            guard_irq <= safe_flag_q && irq_en_q && guard_enable_opt && !global_irq_mask;
            wake_req  <= safe_flag_q && irq_en_q && guard_enable_opt
                      && (wait_mode || active_halt_mode) && !halt_mode;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // checks
    supply_hold_a: assert property (supply_low |=> rst_pin_oe && core_reset)
        else $error("pin not held low during supply drop");
    pulse_width_a: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*8])
        else $error("driven reset pulse too short");
    wdg_drive_a: assert property (wdg_hit |=> rst_pin_oe ##1 rst_pin_oe)
        else $error("watchdog did not drive pin");
    ext_detect_a: assert property (ext_hit |=> rst_pin_oe)
        else $error("external reset not recognised");
    settle_a: assert property ($rose(seq_q == ST_SETTLE) |-> !rst_pin_oe && core_reset [*8])
        else $error("settle phase broken");
    low_phase_a: assert property (seq_q == ST_LOW && cnt_q != 16'(RSTL_OUT - 1) |=> rst_pin_oe)
        else $error("pin released during delay phase");
    irq_gate_a: assert property (global_irq_mask || !irq_en_q |=> !guard_irq)
        else $error("interrupt raised while gated");
    no_halt_wake_a: assert property (halt_mode |=> !wake_req)
        else $error("guard woke device from halt");
    halt_freeze_a: assert property (halt_mode && $past(halt_mode) && !core_reset |-> $stable(status_view))
        else $error("status changed in halt");
    flag_off_a: assert property (!guard_enable_opt |=> !safe_flag_q)
        else $error("safe flag set without guard");
    backup_off_a: assert property (halt_mode |=> !backup_osc_on && !use_backup_q)
        else $error("backup running in halt");
    glitch_free_a: assert property ($changed(use_backup_q) |-> !sys_clk_out && !$past(sys_clk_out))
        else $error("clock switched while high");
    flag_set_a: assert property ($rose(use_backup_q) |-> safe_flag_q || $past(safe_flag_q))
        else $error("backup chosen without flag");

    run_cov: cover property (seq_q == ST_FETCH ##1 seq_q == ST_RUN);
    backup_cov: cover property ($rose(use_backup_q) ##[1:400] $fell(use_backup_q));
    irq_cov: cover property ($rose(guard_irq));
    ext_cov: cover property (ext_hit);

endmodule : reset_and_clock_guard

// >>> include/rcg_pkg.sv
// package for the reset and clock guard block: register map, field layout,
// reset values, oscillator kinds and timing counts.
// assumes a 100 MHz system clock and an apb bus with 32-bit data.
package rcg_pkg;

    // system clock period
    localparam int unsigned CLK_PERIOD_NS   = 10;

    // least external low pulse that is recognised as a reset
    localparam int unsigned T_RSTL_IN_NS    = 20;
    localparam int unsigned RSTL_IN_CYC     = (T_RSTL_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least width of the low pulse that the device drives out
    localparam int unsigned T_RSTL_OUT_NS   = 30000;
    localparam int unsigned RSTL_OUT_CYC    = (T_RSTL_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // oscillator settling phase and vector fetch phase
    localparam int unsigned SETTLE_CYC      = 4096;
    localparam int unsigned FETCH_CYC       = 2;
    // own pin drive takes this many cycles to leave the synchroniser
    localparam int unsigned PIN_HOLDOFF_CYC = 3;

    // clock guard timing, in system clock cycles; recovery count in oscillator edges
    localparam int unsigned SPIKE_MIN_CYC   = 2;
    localparam int unsigned LOSS_CYC        = 64;
    localparam int unsigned GOOD_EDGES      = 8;
    localparam int unsigned BACKUP_HALF_CYC = 50;

    // status register: printed offset is its index, byte address is four times it
    localparam logic [11:0] STATUS_INDEX    = 12'h02B;
    localparam logic [11:0] STATUS_ADDR     = 12'h0AC;

    // field positions
    localparam int unsigned DROP_FLAG_BIT   = 4;
    localparam int unsigned IRQ_EN_BIT      = 2;
    localparam int unsigned SAFE_FLAG_BIT   = 1;
    localparam int unsigned WDG_FLAG_BIT    = 0;

    // reset values
    localparam logic        IRQ_EN_RESET    = 1'b0;
    localparam logic        FLAG_RESET      = 1'b0;

    // main oscillator kinds chosen by option bits
    typedef enum logic [2:0] {
        OSC_EXT_CLOCK,
        OSC_RES_RANGE0,
        OSC_RES_RANGE1,
        OSC_RES_RANGE2,
        OSC_RES_RANGE3,
        OSC_EXT_RC,
        OSC_INT_RC
    } osc_kind_type;

endpackage : rcg_pkg

// >>> hw/clock_spike_filter.sv
// spike filter and loss monitor for the sampled main oscillator.
// assumes osc_in is a level sampled on clk, far slower than clk.
`timescale 1ns/100ps
module clock_spike_filter #(
    parameter int unsigned SPIKE_MIN = rcg_pkg::SPIKE_MIN_CYC,
    parameter int unsigned LOSS      = rcg_pkg::LOSS_CYC,
    parameter int unsigned GOOD      = rcg_pkg::GOOD_EDGES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control
    input  wire logic enable,
    // oscillator in
    input  wire logic osc_in,
    // filtered clock and health
    output logic      osc_clean,
    output logic      osc_good
);

    logic        prev_q;
    logic [15:0] phase_q;
    logic [7:0]  good_cnt_q;
    logic        edge_seen;

    assign edge_seen = osc_in != prev_q;

    // phase length counter, saturating
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q  <= 1'b0;
            phase_q <= 16'h0000;
        end else begin
            prev_q <= osc_in;
            if (edge_seen) begin
                phase_q <= 16'h0000;
            end else if (phase_q != 16'hFFFF) begin
                phase_q <= phase_q + 16'h0001;
            end
        end
    end

    // health: short phase or silence clears, clean edges rebuild
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            good_cnt_q <= 8'h00;
            osc_good   <= 1'b1;
        end else if (!enable) begin
            good_cnt_q <= 8'h00;
            osc_good   <= 1'b1;
        end else if (edge_seen && phase_q < 16'(SPIKE_MIN - 1)) begin
            good_cnt_q <= 8'h00;
            osc_good   <= 1'b0;
        end else if (phase_q >= 16'(LOSS)) begin
            good_cnt_q <= 8'h00;
            osc_good   <= 1'b0;
        end else if (edge_seen && !osc_good) begin
            if (good_cnt_q == 8'(GOOD - 1)) begin
                osc_good   <= 1'b1;
                good_cnt_q <= 8'h00;
            end else begin
                good_cnt_q <= good_cnt_q + 8'h01;
            end
        end
    end

    // pass the oscillator while healthy or while disabled, else hold low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_clean <= 1'b0;
        end else begin
            osc_clean <= (osc_good || !enable) ? osc_in : 1'b0;
        end
    end

endmodule : clock_spike_filter

// >>> verification/osc_reset_partner.sv
// partner model: main oscillator source and external reset circuitry.
// assumes the bench starts and stops the oscillator and asks for pin pulls.
`timescale 1ns/100ps
module osc_reset_partner (
    // clock
    input  wire logic       clk,
    // requests from the bench
    input  wire logic       osc_run,
    input  wire logic [7:0] osc_half,
    input  wire logic       ext_pull_low,
    // reset pin
    input  wire logic       rst_pin_oe,
    output logic            rst_pin_in,
    // oscillator
    output logic            main_osc_in
);
    logic [7:0] cnt_q = 8'h00;
    logic       osc_q = 1'b0;
    // oscillator toggles every osc_half cycles, a stopped one holds its level
    always @(posedge clk) begin
        if (!osc_run) begin
            cnt_q <= 8'h00;
        end else if (cnt_q + 8'h01 >= osc_half) begin
            cnt_q <= 8'h00;
            osc_q <= ~osc_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign main_osc_in = osc_q;
    // open drain with pull-up: parties only pull low, never drive high
    assign rst_pin_in = (rst_pin_oe || ext_pull_low) ? 1'b0 : 1'b1;
endmodule : osc_reset_partner

// >>> verification/reset_and_clock_guard_tb_top.sv
// self-checking bench for the reset and clock guard block.
// assumes shortened low and settle counts and the apb timing of the note.
`timescale 1ns/100ps
module reset_and_clock_guard_tb_top;
    localparam int unsigned RSTL_OUT = 8;
    localparam int unsigned SETTLE   = 16;
    localparam logic [11:0] SR       = rcg_pkg::STATUS_ADDR;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic        rst_pin_in, rst_pin_out, rst_pin_oe, supply_low, wdg_underflow;
    logic [2:0]  osc_select_opt, osc_kind;
    logic        guard_enable_opt, main_osc_in, sys_clk_out, resonator_run, backup_osc_on;
    logic        wait_mode, halt_mode, active_halt_mode, global_irq_mask, core_reset;
    logic        guard_irq, wake_req, osc_run, ext_pull_low, er, ok, last_clk;
    logic [7:0]  osc_half;
    int          n_mismatch, n_tests, cycles, n, run_len;

    reset_and_clock_guard #(.SETTLE(SETTLE), .RSTL_OUT(RSTL_OUT), .RSTL_IN(2)) DUT (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .supply_low(supply_low), .wdg_underflow(wdg_underflow), .osc_select_opt(osc_select_opt),
        .guard_enable_opt(guard_enable_opt), .main_osc_in(main_osc_in), .sys_clk_out(sys_clk_out),
        .resonator_run(resonator_run), .osc_kind(osc_kind), .backup_osc_on(backup_osc_on),
        .wait_mode(wait_mode), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
        .global_irq_mask(global_irq_mask), .core_reset(core_reset), .guard_irq(guard_irq),
        .wake_req(wake_req));

    osc_reset_partner PARTNER (.clk(clk), .osc_run(osc_run), .osc_half(osc_half),
        .ext_pull_low(ext_pull_low), .rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in),
        .main_osc_in(main_osc_in));

    // clock
    always #5 clk = ~clk;

    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_run();
        do @(posedge clk); while (core_reset !== 1'b0);
    endtask : wait_run

    // count cycles that the pin stays driven
    task automatic oe_len();
        n = 0;
        while (rst_pin_oe === 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask : oe_len

    // hang guard and clock phase monitor
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
        if (sys_clk_out !== last_clk && core_reset === 1'b0) begin
            chk("sys_clk_phase", 32'(run_len >= 1), 32'h0000_0001);
        end
        run_len = (sys_clk_out === last_clk) ? run_len + 1 : 0;
        last_clk = sys_clk_out;
    end

    // main sequence
    initial begin
        {clk, psel, penable, pwrite, paddr, pwdata, supply_low, wdg_underflow} = '0;
        {osc_select_opt, guard_enable_opt, wait_mode, halt_mode, active_halt_mode} = '0;
        {global_irq_mask, ext_pull_low, n_mismatch, n_tests, cycles, run_len} = '0;
        {sys_rst, osc_run, last_clk, osc_half, seed} = {1'b1, 1'b1, 1'b0, 8'h04, 32'h3663_15d6};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        oe_len();
        chk("low_phase", 32'(n >= RSTL_OUT - 1), 32'h0000_0001);
        n = 0;
        while (core_reset === 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("settle_len", n, SETTLE + rcg_pkg::FETCH_CYC + 1);
        apb(1'b0, SR, 32'h0000_0000);
        chk("status_reset", rd, 32'h0000_0000);
        seed = lfsr_next(seed);
        apb(1'b1, SR, seed & 32'h0000_0004);
        apb(1'b0, SR, 32'h0000_0000);
        chk("irq_en_rw", rd, seed & 32'h0000_0004);
        apb(1'b0, 12'h0B0, 32'h0000_0000);
        chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
        chk("unmapped_data", rd, 32'h0000_0000);
        // watchdog underflow
        @(posedge clk) wdg_underflow <= 1'b1;
        @(posedge clk) wdg_underflow <= 1'b0;
        @(posedge clk);
        chk("wdg_pin", {31'h0, rst_pin_oe}, 32'h0000_0001);
        oe_len();
        chk("wdg_width", 32'(n >= RSTL_OUT - 1), 32'h0000_0001);
        wait_run();
        apb(1'b0, SR, 32'h0000_0000);
        chk("wdg_flag", rd, 32'h0000_0001);
        // supply drop held for a while
        supply_low <= 1'b1;
        repeat (3) @(posedge clk);
        ok = 1'b1;
        repeat (40) begin
            @(posedge clk);
            ok = ok & rst_pin_oe;
        end
        chk("supply_hold", {31'h0, ok}, 32'h0000_0001);
        supply_low <= 1'b0;
        wait_run();
        apb(1'b0, SR, 32'h0000_0000);
        chk("supply_flag", rd, 32'h0000_0010);
        apb(1'b1, SR, 32'h0000_0000);
        apb(1'b0, SR, 32'h0000_0000);
        chk("flag_clear", rd, 32'h0000_0000);
        // external pulse of random width while halted, then option sweep in reset
        halt_mode    <= 1'b1;
        ext_pull_low <= 1'b1;
        seed = lfsr_next(seed);
        repeat (4 + seed[1:0]) @(posedge clk);
        ext_pull_low <= 1'b0;
        ok = 1'b0;
        repeat (8) begin
            @(posedge clk);
            ok = ok | rst_pin_oe;
        end
        chk("ext_pin", {31'h0, ok}, 32'h0000_0001);
        for (int k = 0; k < 7; k++) begin
            osc_select_opt <= 3'(k);
            repeat (2) @(posedge clk);
            chk("osc_kind", {29'h0, osc_kind}, k);
            chk("res_run", {31'h0, resonator_run}, 32'(k >= 1 && k <= 4));
        end
        chk("still_reset", {31'h0, core_reset}, 32'h0000_0001);
        halt_mode      <= 1'b0;
        osc_select_opt <= 3'h1;
        wait_run();
        // clock loss with guard on, first masked
        guard_enable_opt <= 1'b1;
        global_irq_mask  <= 1'b1;
        wait_mode        <= 1'b1;
        apb(1'b1, SR, 32'h0000_0004);
        chk("guard_on", {31'h0, backup_osc_on}, 32'h0000_0001);
        osc_run <= 1'b0;
        n = 0;
        repeat (400) begin
            @(posedge clk);
            n = n + 32'(sys_clk_out !== last_clk);
        end
        chk("backup_runs", 32'(n >= 2), 32'h0000_0001);
        chk("irq_masked", {31'h0, guard_irq}, 32'h0000_0000);
        apb(1'b0, SR, 32'h0000_0000);
        chk("safe_flag", rd, 32'h0000_0006);
        global_irq_mask <= 1'b0;
        repeat (3) @(posedge clk);
        chk("irq_raised", {31'h0, guard_irq}, 32'h0000_0001);
        chk("wait_wake", {31'h0, wake_req}, 32'h0000_0001);
        osc_half <= 8'h03;
        osc_run  <= 1'b1;
        repeat (300) @(posedge clk);
        apb(1'b0, SR, 32'h0000_0000);
        chk("flag_read", rd, 32'h0000_0006);
        apb(1'b0, SR, 32'h0000_0000);
        chk("flag_gone", rd, 32'h0000_0004);
        // halt freezes the register and stops the guard
        halt_mode <= 1'b1;
        apb(1'b1, SR, 32'h0000_0000);
        chk("halt_guard", {31'h0, backup_osc_on}, 32'h0000_0000);
        chk("halt_no_wake", {31'h0, wake_req}, 32'h0000_0000);
        halt_mode <= 1'b0;
        apb(1'b0, SR, 32'h0000_0000);
        chk("halt_frozen", rd, 32'h0000_0004);
        // guard disabled by option: loss gives no flag
        guard_enable_opt <= 1'b0;
        osc_run          <= 1'b0;
        repeat (300) @(posedge clk);
        apb(1'b0, SR, 32'h0000_0000);
        chk("opt_off_flag", rd, 32'h0000_0004);
        chk("opt_off", {31'h0, backup_osc_on}, 32'h0000_0000);
        stop_test();
    end
endmodule : reset_and_clock_guard_tb_top
